/* File: bench/lsq_peer_model.sv */
// Purpose: peer station on the far side of the link sequencer
// Assumes: decoded frames in both directions, one clock
// Notes:   slow_ff stalls every other cycle; rx lines go to inverse after a frame
`timescale 1ns/1ps
module lsq_peer_model (
	input  wire logic             clk_i,
	input  wire lsq_pkg::lsq_tx_t tx_i,
	input  wire logic             tx_valid_i,
	output logic                  tx_ready_o,
	output lsq_pkg::lsq_rx_t      rx_o,
	output logic                  rx_valid_o
);
	lsq_pkg::lsq_tx_t q[$];
	logic             slow_ff = 1'b0;

	initial begin
		tx_ready_o = 1'b0;
		rx_o = '0;
		rx_valid_o = 1'b0;
	end

	// take frame orders; slow mode makes the sequencer hold its order longer
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o)
			q.push_back(tx_i);
		tx_ready_o <= slow_ff ? ~tx_ready_o : 1'b1;
	end

	// one good frame; stale fields are inverted so nothing reuses them by luck
	task send(input lsq_pkg::lsq_kind_t k, input logic [2:0] ns, nr, input logic pf, em);
		@(posedge clk_i);
		rx_o <= '{k, ns, nr, pf, 1'b1, em};
		rx_valid_o <= 1'b1;
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_o <= ~rx_o;
	endtask
endmodule

/* File: bench/test_lsq_link_sequencer.sv */
// Purpose: self-checking bench of the link sequencer
// Assumes: 25 MHz clock, short T1 and N1 written by software
// Notes:   frames compared on kind, N(S) of I, N(R) and P/F of I and S
`timescale 1ns/1ps
module test_lsq_link_sequencer;
	logic             clk_i = 1'b0;
	logic             srst_i = 1'b1;
	logic [7:0]       addr_i = 8'h00;
	logic [31:0]      wdata_i = 32'h0;
	logic             we_i = 1'b0;
	logic             re_i = 1'b0;
	logic             i_pend_i = 1'b0;
	logic             frmr_i = 1'b0;
	logic [31:0]      rdata_o, st, d;
	lsq_pkg::lsq_rx_t rx_i;
	lsq_pkg::lsq_tx_t tx_o, f;
	logic             rx_valid_i, tx_valid_o, tx_ready_i, tx_abort_o, take_o, dlv_o, dlv_empty_o;
	logic [2:0]       take_ns_o;
	int               err_total = 0;
	int               num_checks = 0;
	int               cyc = 0;

	lsq_link_sequencer i_dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
		.re_i(re_i), .rdata_o(rdata_o), .rx_i(rx_i), .rx_valid_i(rx_valid_i), .tx_o(tx_o), .tx_valid_o(tx_valid_o),
		.tx_ready_i(tx_ready_i), .tx_abort_o(tx_abort_o), .i_pend_i(i_pend_i), .frmr_i(frmr_i), .take_o(take_o),
		.take_ns_o(take_ns_o), .dlv_o(dlv_o), .dlv_empty_o(dlv_empty_o));
	lsq_peer_model i_peer (.clk_i(clk_i), .tx_i(tx_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
		.rx_o(rx_i), .rx_valid_o(rx_valid_i));

	initial begin
		forever #20 clk_i = ~clk_i;
	end

	task print_verdict();
		if (err_total == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		we_i <= 1'b1;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1 v = rdata_o;
	endtask

	// next frame taken by the peer, bounded wait; U frames are judged on kind only
	task fx(input lsq_pkg::lsq_kind_t k, input logic [2:0] ns, nr, input logic pf);
		int n;
		n = 0;
		while (i_peer.q.size() == 0 && n < 1500) begin
			@(posedge clk_i);
			n++;
		end
		if (i_peer.q.size() > 0)
			f = i_peer.q.pop_front();
		else
			f = '1;
		chk({f.kind, (k == lsq_pkg::K_I) ? f.ns : 3'h0, (k < lsq_pkg::K_SABM) ? {f.nr, f.pf} : 4'h0},
			{k, (k == lsq_pkg::K_I) ? ns : 3'h0, (k < lsq_pkg::K_SABM) ? {nr, pf} : 4'h0});
	endtask

	task none(input int c);
		repeat (c) @(posedge clk_i);
		#1 chk(i_peer.q.size(), 0);
	endtask

	task flush();
		repeat (8) @(posedge clk_i);
		i_peer.q.delete();
	endtask

	// run-away guard; the sequence needs about a thousand cycles
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end

	initial begin
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		// reset contents, unmapped and read-only places
		rd(lsq_pkg::REG_T1, d);
		chk(d, {8'h00, lsq_pkg::T1_RST});
		rd(lsq_pkg::REG_N1, d);
		chk(d, {28'h0, lsq_pkg::N1_RST});
		wr(lsq_pkg::REG_STAT, 32'hFFFFFFFF);
		rd(8'h18, d);
		chk(d, 32'h0);
		rd(lsq_pkg::REG_STAT, d);
		chk(d, 32'h0);
		// set-up with no answer: retries then give up
		wr(lsq_pkg::REG_T1, 32'h14);
		wr(lsq_pkg::REG_N1, 32'h3);
		wr(lsq_pkg::REG_DST, 32'h1234);
		wr(lsq_pkg::REG_SRC, 32'h5678);
		i_peer.slow_ff = 1'b1;
		wr(lsq_pkg::REG_CTRL, 32'h1);
		fx(lsq_pkg::K_SABM, 3'h0, 3'h0, 1'b0);
		chk({f.dst, f.src}, 32'h12345678);
		none(12);
		fx(lsq_pkg::K_SABM, 3'h0, 3'h0, 1'b0);
		repeat (200) @(posedge clk_i);
		rd(lsq_pkg::REG_STAT, d);
		chk({d[18], d[1:0]}, 3'b100);
		// set-up answered by UA
		i_peer.slow_ff = 1'b0;
		i_peer.q.delete();
		wr(lsq_pkg::REG_T1, 32'h190);
		wr(lsq_pkg::REG_CTRL, 32'h1);
		fx(lsq_pkg::K_SABM, 3'h0, 3'h0, 1'b0);
		i_peer.send(lsq_pkg::K_UA, 3'h0, 3'h0, 1'b1, 1'b0);
		rd(lsq_pkg::REG_STAT, d);
		chk({d[19], d[14:12], d[10:8], d[6:4], d[1:0]}, 12'h002);
		// numbering and the seven-frame window across the wrap
		i_pend_i <= 1'b1;
		for (int i = 0; i < 7; i++)
			fx(lsq_pkg::K_I, 3'(i), 3'h0, 1'b0);
		none(30);
		i_peer.send(lsq_pkg::K_RR, 3'h0, 3'h3, 1'b0, 1'b0);
		for (int i = 7; i < 10; i++)
			fx(lsq_pkg::K_I, 3'(i), 3'h0, 1'b0);
		none(30);
		// reject from the peer rewinds the send count
		i_pend_i <= 1'b0;
		i_peer.send(lsq_pkg::K_REJ, 3'h0, 3'h5, 1'b0, 1'b0);
		rd(lsq_pkg::REG_STAT, d);
		chk(d[6:4], 3'h5);
		i_pend_i <= 1'b1;
		fx(lsq_pkg::K_I, 3'h5, 3'h0, 1'b0);
		i_pend_i <= 1'b0;
		flush();
		rd(lsq_pkg::REG_STAT, st);
		i_peer.send(lsq_pkg::K_RR, 3'h0, st[6:4], 1'b0, 1'b0);
		// receive in sequence, empty, out of sequence
		i_peer.send(lsq_pkg::K_I, 3'h0, st[6:4], 1'b0, 1'b0);
		#1 chk({dlv_o, dlv_empty_o}, 2'b10);
		fx(lsq_pkg::K_RR, 3'h0, 3'h1, 1'b0);
		i_peer.send(lsq_pkg::K_I, 3'h1, st[6:4], 1'b0, 1'b1);
		#1 chk({dlv_o, dlv_empty_o}, 2'b11);
		fx(lsq_pkg::K_RR, 3'h0, 3'h2, 1'b0);
		i_peer.send(lsq_pkg::K_I, 3'h5, st[6:4], 1'b0, 1'b0);
		#1 chk(dlv_o, 1'b0);
		fx(lsq_pkg::K_REJ, 3'h0, 3'h2, 1'b0);
		// local busy: polls answered RNR final, I frames dropped
		wr(lsq_pkg::REG_CTRL, 32'h2);
		flush();
		i_peer.send(lsq_pkg::K_RR, 3'h0, st[6:4], 1'b1, 1'b0);
		fx(lsq_pkg::K_RNR, 3'h0, 3'h2, 1'b1);
		i_peer.send(lsq_pkg::K_I, 3'h2, st[6:4], 1'b0, 1'b0);
		#1 chk(dlv_o, 1'b0);
		fx(lsq_pkg::K_RNR, 3'h0, 3'h2, 1'b0);
		wr(lsq_pkg::REG_CTRL, 32'h0);
		flush();
		// frame rejection holds I frames back; release piggybacks N(R)
		frmr_i <= 1'b1;
		i_pend_i <= 1'b1;
		none(30);
		frmr_i <= 1'b0;
		fx(lsq_pkg::K_I, st[6:4], 3'h2, 1'b0);
		i_pend_i <= 1'b0;
		flush();
		// busy peer with frames outstanding: periodic poll on T1
		i_peer.send(lsq_pkg::K_RNR, 3'h0, st[6:4], 1'b0, 1'b0);
		fx(lsq_pkg::K_RR, 3'h0, 3'h2, 1'b1);
		// incoming set-up resets both counts
		i_peer.q.delete();
		i_peer.send(lsq_pkg::K_SABM, 3'h0, 3'h0, 1'b1, 1'b0);
		fx(lsq_pkg::K_UA, 3'h0, 3'h0, 1'b1);
		rd(lsq_pkg::REG_STAT, d);
		chk({d[10:8], d[6:4], d[1:0]}, 8'h02);
		print_verdict();
	end
endmodule

/* File: inc/lsq_pkg.sv */
// Functional notes
// [R01] frames carry destination then source address
// [R02] link open: send SABM, start T1
// [R03] answer SABM with UA, zero V(S), V(R)
// [R04] UA received: stop T1, zero state variables
// [R05] T1 expiry resends SABM until N1 tries
// [R06] I frame N(S)=V(S), then V(S)+1
// [R07] stop new I frames at window seven
// [R08] locally busy may send if peer not busy
// [R09] frame-rejection condition stops I frames
// [R10] in-sequence I frame accepted, V(R) incremented
// [R11] pending I frame piggybacks the acknowledgement
// [R12] nothing queued: answer with RR N(R)=V(R)
// [R13] busy: discard I frames, repeat busy indication
// [R14] poll a busy peer periodically
// [R15] empty I frame reported without payload
// [R16] out-of-sequence I: discard, send REJ once
// [R17] every I/S N(R) checked, T1 reset/restarted
// [R18] T1 expiry with outstanding frames: retransmit
// [R19] REJ loads V(S) with its N(R)
// [R20] idle REJ retransmits now; U/S finishes
// [R21] full duplex REJ aborts current I frame
// [R22] retransmission never exceeds seven-frame window
// [R23] busy: polled S frame answered RNR final
// [R24] T1 and N1 programmable by software
//
// Purpose: constants and carriers of the link sequencer
// Assumes: one 25 MHz clock, synchronous reset
// Notes:   register offsets are byte addresses of 32-bit words
package lsq_pkg;
	localparam logic [7:0]  REG_CTRL   = 8'h00;  // b0 connect, b1 local busy, b2 full duplex
	localparam logic [7:0]  REG_T1     = 8'h04;  // T1 in clock cycles
	localparam logic [7:0]  REG_N1     = 8'h08;  // retry limit
	localparam logic [7:0]  REG_DST    = 8'h0C;  // peer station address
	localparam logic [7:0]  REG_SRC    = 8'h10;  // own station address
	localparam logic [7:0]  REG_STAT   = 8'h14;  // read-only status
	localparam int          CTRL_CONN  = 0;
	localparam int          CTRL_BUSY  = 1;
	localparam int          CTRL_FDX   = 2;
	localparam logic [23:0] T1_RST     = 24'h0186A0;  // 4 ms at 25 MHz
	localparam logic [3:0]  N1_RST     = 4'hA;
	localparam logic [2:0]  WINDOW     = 3'h7;
	localparam logic [2:0]  SEQ_ONE    = 3'h1;

	typedef enum logic [2:0] {K_I, K_RR, K_RNR, K_REJ, K_SABM, K_UA} lsq_kind_t;
	typedef enum logic [1:0] {LS_IDLE, LS_SETUP, LS_LINK} lsq_st_t;

	// decoded received frame
	typedef struct packed {
		lsq_kind_t   kind;
		logic [2:0]  ns;
		logic [2:0]  nr;
		logic        pf;
		logic        fcs_ok;
		logic        empty;
	} lsq_rx_t;

	// frame order to the framer; destination ahead of source
	typedef struct packed {
		logic [15:0] dst;
		logic [15:0] src;
		lsq_kind_t   kind;
		logic [2:0]  ns;
		logic [2:0]  nr;
		logic        pf;
	} lsq_tx_t;

	typedef struct packed {
		lsq_st_t     st;
		lsq_tx_t     tx;
		logic        tx_v;
		logic [2:0]  vs;
		logic [2:0]  vr;
		logic [2:0]  va;
		logic [3:0]  retry;
		logic [23:0] t1_cnt;
		logic        t1_run;
		logic [23:0] t1_val;
		logic [3:0]  n1;
		logic [15:0] dst;
		logic [15:0] src;
		logic        busy;
		logic        busy_q;
		logic        fdx;
		logic        peer_busy;
		logic        rej_sent;
		logic        fail;
		logic        p_ua;
		logic        p_sabm;
		logic        p_rr;
		logic        p_rnr;
		logic        p_rej;
		logic        p_f;
		logic        p_poll;
		logic        take;
		logic [2:0]  take_ns;
		logic        dlv;
		logic        dlv_empty;
		logic        abort;
		logic [31:0] rdata;
	} lsq_state_t;
endpackage

/* File: rtl/lsq_link_sequencer.sv */
// Purpose: sequencing engine of a balanced packet link (set-up, numbering, ack, reject)
// Assumes: framer outside builds frames from tx_o and decodes received frames into rx_i
// Notes:   I frame payloads live in the user store, addressed by the N(S) on take_ns_o
`timescale 1ns/1ps
module lsq_link_sequencer (
	input  wire logic            clk_i,
	input  wire logic            srst_i,
	input  wire logic [7:0]      addr_i,
	input  wire logic [31:0]     wdata_i,
	input  wire logic            we_i,
	input  wire logic            re_i,
	output logic      [31:0]     rdata_o,
	input  wire lsq_pkg::lsq_rx_t rx_i,
	input  wire logic            rx_valid_i,
	output lsq_pkg::lsq_tx_t     tx_o,
	output logic                 tx_valid_o,
	input  wire logic            tx_ready_i,
	output logic                 tx_abort_o,
	input  wire logic            i_pend_i,
	input  wire logic            frmr_i,
	output logic                 take_o,
	output logic      [2:0]      take_ns_o,
	output logic                 dlv_o,
	output logic                 dlv_empty_o
);
	lsq_pkg::lsq_state_t s;
	lsq_pkg::lsq_state_t n;
	logic                ld;
	logic                rx_ok;
	logic                rx_rej;
	logic                t1_exp;
	logic                can_i;
	logic                s_need;

	assign rx_ok  = rx_valid_i && rx_i.fcs_ok;
	assign rx_rej = rx_ok && s.st == lsq_pkg::LS_LINK && rx_i.kind == lsq_pkg::K_REJ;
	assign t1_exp = s.t1_run && s.t1_cnt >= s.t1_val;
	// [R07] [R08] [R09] window, busy peer, reject gate
	assign can_i  = s.st == lsq_pkg::LS_LINK && i_pend_i && !frmr_i && !s.peer_busy && !rx_rej
	                && (3'(s.vs - s.va) != lsq_pkg::WINDOW);
	assign s_need = s.p_rnr || s.p_rej || s.p_f || s.p_poll || (s.p_rr && !can_i);
	assign ld     = !s.tx_v || tx_ready_i;

	// next state: registers, transmit slot, T1, then receive (receive sets win over load clears)
	always_comb begin
		n           = s;
		n.take      = 1'b0;
		n.dlv       = 1'b0;
		n.abort     = 1'b0;
		n.rdata     = 32'h00000000;
		n.busy_q    = s.busy;
		if (s.t1_run) begin
			n.t1_cnt = 24'(s.t1_cnt + 24'h000001);
		end
		// register writes
		if (we_i) begin
			unique case (addr_i)
				lsq_pkg::REG_CTRL: begin
					n.busy = wdata_i[lsq_pkg::CTRL_BUSY];
					n.fdx  = wdata_i[lsq_pkg::CTRL_FDX];
					// [R02] connect request
					if (wdata_i[lsq_pkg::CTRL_CONN] && s.st == lsq_pkg::LS_IDLE) begin
						n.st     = lsq_pkg::LS_SETUP;
						n.p_sabm = 1'b1;
						n.retry  = 4'h0;
						n.fail   = 1'b0;
					end
				end
				// [R24] programmable timing
				lsq_pkg::REG_T1: n.t1_val = wdata_i[23:0];
				lsq_pkg::REG_N1: n.n1 = wdata_i[3:0];
				lsq_pkg::REG_DST: n.dst = wdata_i[15:0];
				lsq_pkg::REG_SRC: n.src = wdata_i[15:0];
				default: ;
			endcase
		end
		// reads answer one cycle later; unmapped reads give zero
		if (re_i) begin
			unique case (addr_i)
				lsq_pkg::REG_CTRL: n.rdata = {29'h0, s.fdx, s.busy, 1'b0};
				lsq_pkg::REG_T1:   n.rdata = {8'h00, s.t1_val};
				lsq_pkg::REG_N1:   n.rdata = {28'h0, s.n1};
				lsq_pkg::REG_DST:  n.rdata = {16'h0000, s.dst};
				lsq_pkg::REG_SRC:  n.rdata = {16'h0000, s.src};
				lsq_pkg::REG_STAT: n.rdata = {8'h00, s.retry, s.t1_run, s.fail, s.rej_sent, s.peer_busy,
				                              1'b0, s.va, 1'b0, s.vr, 1'b0, s.vs, 2'b00, s.st};
				default:           n.rdata = 32'h00000000;
			endcase
		end
		// busy edges announce themselves with RNR or RR
		if (s.busy && !s.busy_q) begin
			n.p_rnr = 1'b1;
		end
		if (!s.busy && s.busy_q) begin
			n.p_rr = 1'b1;
		end
		if (s.tx_v && tx_ready_i) begin
			n.tx_v = 1'b0;
		end
		// transmit slot: UA, SABM, supervisory, then I frames
		if (ld) begin
			// [R01] address order
			n.tx.dst = s.dst;
			n.tx.src = s.src;
			n.tx.ns  = s.vs;
			n.tx.nr  = s.vr;
			n.tx.pf  = 1'b0;
			if (s.p_ua) begin
				n.tx.kind = lsq_pkg::K_UA;
				n.tx_v    = 1'b1;
				n.p_ua    = 1'b0;
			end else if (s.p_sabm) begin
				// [R02] T1 starts with SABM
				n.tx.kind = lsq_pkg::K_SABM;
				n.tx_v    = 1'b1;
				n.p_sabm  = 1'b0;
				n.t1_run  = 1'b1;
				n.t1_cnt  = 24'h000000;
			end else if (s_need && s.st == lsq_pkg::LS_LINK) begin
				// [R23] busy answers with RNR
				n.tx.kind = s.busy ? lsq_pkg::K_RNR : (s.p_rej ? lsq_pkg::K_REJ : lsq_pkg::K_RR);
				n.tx.pf   = s.p_f || s.p_poll;
				n.tx_v    = 1'b1;
				{n.p_rr, n.p_rnr, n.p_rej, n.p_f, n.p_poll} = 5'h00;
			end else if (can_i) begin
				// [R06] [R11] numbered, piggybacked
				n.tx.kind = lsq_pkg::K_I;
				n.tx_v    = 1'b1;
				n.vs      = 3'(s.vs + lsq_pkg::SEQ_ONE);
				n.p_rr    = 1'b0;
				n.take    = 1'b1;
				n.take_ns = s.vs;
				if (!s.t1_run) begin
					n.t1_run = 1'b1;
					n.t1_cnt = 24'h000000;
				end
			end
		end
		// T1 expiry
		if (t1_exp) begin
			n.t1_cnt = 24'h000000;
			if (s.st != lsq_pkg::LS_IDLE && 4'(s.retry + 4'h1) >= s.n1) begin
				// [R05] retry limit reached
				n.st     = lsq_pkg::LS_IDLE;
				n.fail   = 1'b1;
				n.t1_run = 1'b0;
				n.p_sabm = 1'b0;
			end else if (s.st == lsq_pkg::LS_SETUP) begin
				// [R05] resend SABM, T1 restarts at send
				n.retry  = 4'(s.retry + 4'h1);
				n.p_sabm = 1'b1;
				n.t1_run = 1'b0;
			end else if (s.vs != s.va) begin
				// [R18] go back to first unacknowledged
				n.retry  = 4'(s.retry + 4'h1);
				n.vs     = s.va;
				n.p_poll = 1'b1;
			end else if (s.peer_busy) begin
				// [R14] periodic poll of busy peer
				n.p_poll = 1'b1;
			end else begin
				n.t1_run = 1'b0;
			end
		end
		// receive side
		if (rx_ok) begin
			if (rx_i.kind == lsq_pkg::K_SABM) begin
				// [R03] accept connection
				n.st        = lsq_pkg::LS_LINK;
				n.p_ua      = 1'b1;
				n.vs        = 3'h0;
				n.vr        = 3'h0;
				n.va        = 3'h0;
				n.retry     = 4'h0;
				n.t1_run    = 1'b0;
				n.peer_busy = 1'b0;
				n.rej_sent  = 1'b0;
				n.p_sabm    = 1'b0;
			end else if (rx_i.kind == lsq_pkg::K_UA) begin
				if (s.st == lsq_pkg::LS_SETUP) begin
					// [R04] link up
					n.st     = lsq_pkg::LS_LINK;
					n.t1_run = 1'b0;
					n.vs     = 3'h0;
					n.vr     = 3'h0;
					n.va     = 3'h0;
					n.retry  = 4'h0;
				end
			end else if (s.st == lsq_pkg::LS_LINK) begin
				if (rx_i.kind == lsq_pkg::K_REJ) begin
					// [R19] [R22] restart from requested frame
					n.vs = rx_i.nr;
					// [R21] [R20] full duplex aborts I only
					if (n.tx_v && n.tx.kind == lsq_pkg::K_I && s.fdx) begin
						n.tx_v  = 1'b0;
						n.abort = 1'b1;
					end
				end
				// [R17] acknowledgement check
				if (rx_i.nr != s.va) begin
					n.va     = rx_i.nr;
					n.retry  = 4'h0;
					n.t1_cnt = 24'h000000;
					n.t1_run = n.vs != rx_i.nr;
				end
				if (rx_i.kind == lsq_pkg::K_I) begin
					if (s.busy) begin
						// [R13] discard, repeat busy
						n.p_rnr = 1'b1;
					end else if (rx_i.ns == s.vr) begin
						// [R10] [R15] [R12] accept and acknowledge
						n.vr        = 3'(s.vr + lsq_pkg::SEQ_ONE);
						n.dlv       = 1'b1;
						n.dlv_empty = rx_i.empty;
						n.rej_sent  = 1'b0;
						n.p_rr      = 1'b1;
					end else if (!s.rej_sent) begin
						// [R16] one outstanding reject
						n.p_rej    = 1'b1;
						n.rej_sent = 1'b1;
					end
					if (rx_i.pf) begin
						n.p_f = 1'b1;
					end
				end else begin
					n.peer_busy = rx_i.kind == lsq_pkg::K_RNR;
					// [R23] polled S frame gets a final answer
					if (rx_i.pf) begin
						n.p_f = 1'b1;
					end
				end
			end
		end
	end

	// single state register
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s        <= '0;
			s.t1_val <= lsq_pkg::T1_RST;
			s.n1     <= lsq_pkg::N1_RST;
		end else begin
			s <= n;
		end
	end

	assign rdata_o     = s.rdata;
	assign tx_o        = s.tx;
	assign tx_valid_o  = s.tx_v;
	assign tx_abort_o  = s.abort;
	assign take_o      = s.take;
	assign take_ns_o   = s.take_ns;
	assign dlv_o       = s.dlv;
	assign dlv_empty_o = s.dlv_empty;

	// checks of the sequencing behaviour
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	property p_window;
		take_o |-> 3'(take_ns_o - s.va) != lsq_pkg::WINDOW;
	endproperty
	a_window: assert property (p_window) else $error("I frame sent beyond window"); // [R07]

	property p_vs_step;
		ld && can_i && !s.p_ua && !s.p_sabm && !s_need && !rx_valid_i && !t1_exp
		|=> take_o && s.vs == 3'($past(s.vs) + 3'h1) && take_ns_o == $past(s.vs);
	endproperty
	a_vs_step: assert property (p_vs_step) else $error("send variable not stepped"); // [R06]

	property p_frmr;
		frmr_i |-> !can_i;
	endproperty
	a_frmr: assert property (p_frmr) else $error("I frame allowed while rejecting"); // [R09]

	property p_accept;
		rx_ok && s.st == lsq_pkg::LS_LINK && rx_i.kind == lsq_pkg::K_I && !s.busy && rx_i.ns == s.vr
		|=> dlv_o && s.vr == 3'($past(s.vr) + 3'h1) && dlv_empty_o == $past(rx_i.empty);
	endproperty
	a_accept: assert property (p_accept) else $error("in-sequence I frame not accepted"); // [R10]

	property p_busy_drop;
		rx_ok && s.st == lsq_pkg::LS_LINK && rx_i.kind == lsq_pkg::K_I && s.busy
		|=> !dlv_o && s.vr == $past(s.vr) && s.p_rnr;
	endproperty
	a_busy_drop: assert property (p_busy_drop) else $error("busy station took an I frame"); // [R13]

	property p_reject;
		rx_ok && s.st == lsq_pkg::LS_LINK && rx_i.kind == lsq_pkg::K_I && !s.busy && rx_i.ns != s.vr
		&& !s.rej_sent |=> s.p_rej && s.rej_sent && !dlv_o;
	endproperty
	a_reject: assert property (p_reject) else $error("sequence error not rejected"); // [R16]

	property p_sabm_rx;
		rx_ok && rx_i.kind == lsq_pkg::K_SABM |=> s.st == lsq_pkg::LS_LINK && s.vs == 3'h0 && s.vr == 3'h0
		##1 tx_valid_o && tx_o.kind == lsq_pkg::K_UA;
	endproperty
	a_sabm_rx: assert property (p_sabm_rx) else $error("SABM not answered by UA"); // [R03]

	property p_ua_rx;
		rx_ok && rx_i.kind == lsq_pkg::K_UA && s.st == lsq_pkg::LS_SETUP
		|=> s.st == lsq_pkg::LS_LINK && !s.t1_run && s.vs == 3'h0 && s.vr == 3'h0;
	endproperty
	a_ua_rx: assert property (p_ua_rx) else $error("UA did not open the link"); // [R04]

	property p_sabm_t1;
		tx_valid_o && tx_o.kind == lsq_pkg::K_SABM && $rose(tx_valid_o) |-> s.t1_run && s.t1_cnt == 24'h000000;
	endproperty
	a_sabm_t1: assert property (p_sabm_t1) else $error("T1 not started with SABM"); // [R02]

	property p_rej_rx;
		rx_rej |=> s.vs == $past(rx_i.nr);
	endproperty
	a_rej_rx: assert property (p_rej_rx) else $error("REJ did not reload send variable"); // [R19]

	property p_n1;
		t1_exp && s.st == lsq_pkg::LS_SETUP && 4'(s.retry + 4'h1) >= s.n1 && !rx_valid_i
		|=> s.st == lsq_pkg::LS_IDLE && s.fail;
	endproperty
	a_n1: assert property (p_n1) else $error("retry limit ignored"); // [R05]

	// a full window must close the I frame gate, whatever else is pending
	property p_window_gate;
		3'(s.vs - s.va) == lsq_pkg::WINDOW |-> !can_i;
	endproperty
	a_window_gate: assert property (p_window_gate) else $error("window full but I allowed"); // [R07]

	// of the two busy states only the peer's stops I frames, local busy does not
	property p_peer_busy;
		s.peer_busy |-> !can_i;
	endproperty
	a_peer_busy: assert property (p_peer_busy) else $error("I frame allowed to busy peer"); // [R08]

	// an abort only withdraws in full duplex and leaves nothing pending
	property p_abort;
		tx_abort_o |-> $past(s.fdx) && !tx_valid_o;
	endproperty
	a_abort: assert property (p_abort) else $error("abort outside full duplex"); // [R21]

	// half duplex lets the current frame finish
	property p_half_keep;
		rx_rej && !s.fdx |=> !tx_abort_o;
	endproperty
	a_half_keep: assert property (p_half_keep) else $error("half duplex frame aborted"); // [R20]

	// new acknowledgement moves va and resets T1
	property p_ack;
		rx_ok && s.st == lsq_pkg::LS_LINK && rx_i.kind != lsq_pkg::K_SABM && rx_i.kind != lsq_pkg::K_UA
		&& rx_i.nr != s.va |=> s.va == $past(rx_i.nr) && s.t1_cnt == 24'h000000;
	endproperty
	a_ack: assert property (p_ack) else $error("acknowledgement not taken"); // [R17]

	// expiry with frames outstanding rewinds to the first unacknowledged one
	property p_retx;
		t1_exp && s.st == lsq_pkg::LS_LINK && s.vs != s.va && 4'(s.retry + 4'h1) < s.n1 && !rx_valid_i
		|=> s.vs == $past(s.va) && s.p_poll;
	endproperty
	a_retx: assert property (p_retx) else $error("T1 expiry did not retransmit"); // [R18]

	// an idle timer expiry against a busy peer still polls
	property p_poll_busy;
		t1_exp && s.st == lsq_pkg::LS_LINK && s.vs == s.va && s.peer_busy && 4'(s.retry + 4'h1) < s.n1
		&& !rx_valid_i |=> s.p_poll;
	endproperty
	a_poll_busy: assert property (p_poll_busy) else $error("busy peer not polled"); // [R14]
endmodule
